// ### core/sfb_core.sv
// serial frame, mode and baud configuration block with apb registers
`timescale 1ns/1ns
module sfb_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        port_out_value,
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             tx_pin_override,
    output logic             sync_clock_pin_o,
    output logic             sync_clock_pin_oe
);
    import sfb_pkg::*;
    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc_w    = psel && penable;
    wire wr_w     = acc_w && pwrite;
    wire rd_w     = acc_w && !pwrite;
    wire hit_st   = (paddr == SFB_OFF_STATUS);
    wire hit_cb   = (paddr == SFB_OFF_CTRL_B);
    wire hit_fmt  = (paddr == SFB_OFF_FORMAT);
    wire hit_bh   = (paddr == SFB_OFF_BAUD_H);
    wire hit_bl   = (paddr == SFB_OFF_BAUD_L);
    wire hit_dat  = (paddr == SFB_OFF_DATA);
    wire mapped_w = hit_st | hit_cb | hit_fmt | hit_bh | hit_bl | hit_dat;
    assign pready  = 1'b1;
    assign pslverr = acc_w && !mapped_w;

    // ------------------------------------------------------------
    // registers and decoded fields
    // ------------------------------------------------------------
    logic [7:0] fmt_q;
    logic [3:0] div_hi_q;
    logic [7:0] div_lo_q;
    logic       txen_q, sz2_q, tx8_q, u2x_q;
    logic       txc_q, perr_q, rx_full_q, rx8_q;
    logic [7:0] rx_buf_q;
    logic [8:0] txbuf_q;
    logic       txbuf_full_q;
    logic       tx_active_q;
    logic [31:0] prdata_q;
    wire [1:0] mode_w    = fmt_q[7:6];
    wire       sync_w    = (mode_w == SFB_MODE_SYNC) ||
                           (mode_w == SFB_MODE_SPI);
    wire       par_en_w  = fmt_q[5];
    wire       par_odd_w = fmt_q[4];
    wire       stop2_w   = fmt_q[3];
    wire [2:0] size_w    = {sz2_q, fmt_q[2:1]};
    wire [3:0] nbits_w   = (size_w == SFB_SIZE_9) ? 4'h9 :
                           (size_w[2] ? 4'h8 : 4'h5 + {2'b00, fmt_q[2:1]});
    wire [4:0] ratio_w   = u2x_q ? SFB_RATIO_DBL : SFB_RATIO_NORM;
    wire       data_wr_w = wr_w && hit_dat && !txbuf_full_q;
    wire       data_rd_w = rd_w && hit_dat;

    // ------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------
    sfb_baud_if bif();
    wire [7:0] div_lo_w = (wr_w && hit_bl) ? pwdata[7:0] : div_lo_q;
    assign bif.divisor      = {div_hi_q, div_lo_w};
    assign bif.reload       = wr_w && hit_bl;
    assign bif.sync_mode    = sync_w;
    assign bif.double_speed = u2x_q;
    assign bif.polarity     = fmt_q[0];
    sfb_baud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .bif     (bif)
    );
    assign sync_clock_pin_o  = bif.xck;
    assign sync_clock_pin_oe = sync_w;

    // ------------------------------------------------------------
    // register writes and read data
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fmt_q    <= SFB_FORMAT_RST;
            div_hi_q <= 4'h0;
            div_lo_q <= 8'h00;
            txen_q   <= 1'b0;
            sz2_q    <= 1'b0;
            tx8_q    <= 1'b0;
            u2x_q    <= 1'b0;
        end else if (wr_w) begin
            if (hit_fmt) fmt_q <= pwdata[7:0];
            // only the low nibble is kept
            if (hit_bh) div_hi_q <= pwdata[3:0];
            if (hit_bl) div_lo_q <= pwdata[7:0];
            if (hit_st) u2x_q <= pwdata[SFB_ST_U2X];
            if (hit_cb) begin
                txen_q <= pwdata[SFB_CB_TXEN];
                sz2_q  <= pwdata[SFB_CB_SZ2];
                tx8_q  <= pwdata[SFB_CB_TX8];
            end
        end
    end

    wire [7:0] rd_mux_w =
        hit_st  ? {rx_full_q, txc_q, !txbuf_full_q, 2'b00, perr_q,
                   u2x_q, 1'b0} :
        hit_cb  ? {4'h0, txen_q, sz2_q, rx8_q, tx8_q} :
        hit_fmt ? fmt_q :
        hit_bh  ? {4'h0, div_hi_q} :
        hit_bl  ? div_lo_q :
        hit_dat ? rx_buf_q : 8'h00;
    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_q <= 32'h0000_0000;
        else if (psel && !penable) prdata_q <= {24'h000000, rd_mux_w};
    end
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    sfb_tx_state_type tx_state_q;
    logic [8:0] tx_sh_q;
    logic [3:0] tx_bit_q;
    logic       tx_stopc_q, tx_line_q, out_pin_q;
    logic       tx_par_w;
    wire tx_step_w = sync_w ? bif.tx_edge : bif.bit_tick;
    wire tx_load_w = tx_step_w && (tx_state_q == SFB_TX_IDLE) &&
                     txbuf_full_q && tx_active_q;
    wire tx_end_w  = tx_step_w && (tx_state_q == SFB_TX_STOP) &&
                     !tx_stopc_q;

    sfb_parity u_txpar (
        .data  (tx_sh_q),
        .nbits (nbits_w),
        .odd   (par_odd_w),
        .par   (tx_par_w)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= SFB_TX_IDLE;
            tx_sh_q    <= 9'h000;
            tx_bit_q   <= 4'h0;
            tx_stopc_q <= 1'b0;
            tx_line_q  <= 1'b1;
        end else if (tx_step_w) begin
            case (tx_state_q)
                SFB_TX_IDLE: if (tx_load_w) begin
                    tx_sh_q    <= txbuf_q;
                    tx_line_q  <= 1'b0;
                    tx_state_q <= SFB_TX_START;
                end
                SFB_TX_START: begin
                    tx_line_q  <= tx_sh_q[0];
                    tx_bit_q   <= 4'h0;
                    tx_state_q <= SFB_TX_DATA;
                end
                SFB_TX_DATA: if (tx_bit_q == nbits_w - 4'h1) begin
                    tx_line_q  <= par_en_w ? tx_par_w : 1'b1;
                    tx_stopc_q <= stop2_w;
                    tx_state_q <= par_en_w ? SFB_TX_PAR : SFB_TX_STOP;
                end else begin
                    tx_bit_q  <= tx_bit_q + 4'h1;
                    tx_line_q <= tx_sh_q[tx_bit_q + 4'h1];
                end
                SFB_TX_PAR: begin
                    tx_line_q  <= 1'b1;
                    tx_state_q <= SFB_TX_STOP;
                end
                SFB_TX_STOP: begin
                    if (tx_stopc_q) tx_stopc_q <= 1'b0;
                    else tx_state_q <= SFB_TX_IDLE;
                end
                default: tx_state_q <= SFB_TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txbuf_q      <= 9'h000;
            txbuf_full_q <= 1'b0;
            txc_q        <= 1'b0;
            tx_active_q  <= 1'b0;
            out_pin_q    <= 1'b1;
        end else begin
            // ninth bit taken with the data write
            if (data_wr_w) txbuf_q <= {tx8_q, pwdata[7:0]};
            if (data_wr_w) txbuf_full_q <= 1'b1;
            else if (tx_load_w) txbuf_full_q <= 1'b0;
            if (tx_end_w && !txbuf_full_q) txc_q <= 1'b1;
            else if (wr_w && hit_st && pwdata[SFB_ST_TXC]) txc_q <= 1'b0;
            if (txen_q) tx_active_q <= 1'b1;
            else if (tx_state_q == SFB_TX_IDLE && !txbuf_full_q)
                tx_active_q <= 1'b0;
            out_pin_q <= tx_active_q ? tx_line_q : port_out_value;
        end
    end
    assign serial_out_pin  = out_pin_q;
    assign tx_pin_override = tx_active_q;

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    sfb_rx_state_type rx_state_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_bit_q;
    logic [4:0] rx_cnt_q;
    logic       rx_pbit_q, rx_par_w;
    wire [4:0] rx_tgt_w  = (rx_state_q == SFB_RX_START) ?
                           (ratio_w >> 1) - 5'h01 : ratio_w - 5'h01;
    wire       rx_samp_w = sync_w ? bif.rx_edge :
                           (bif.tick && rx_cnt_q == rx_tgt_w &&
                            rx_state_q != SFB_RX_IDLE);
    wire       rx_done_w = rx_samp_w && (rx_state_q == SFB_RX_STOP);

    sfb_parity u_rxpar (
        .data  (rx_sh_q),
        .nbits (nbits_w),
        .odd   (par_odd_w),
        .par   (rx_par_w)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= SFB_RX_IDLE;
            rx_cnt_q   <= 5'h00;
        end else begin
            if (rx_state_q == SFB_RX_IDLE || sync_w) rx_cnt_q <= 5'h00;
            else if (bif.tick)
                rx_cnt_q <= (rx_cnt_q == rx_tgt_w) ? 5'h00 :
                            rx_cnt_q + 5'h01;
            case (rx_state_q)
                SFB_RX_IDLE: if (!serial_in_pin &&
                                 (!sync_w || bif.rx_edge))
                    rx_state_q <= sync_w ? SFB_RX_DATA : SFB_RX_START;
                SFB_RX_START: if (rx_samp_w)
                    rx_state_q <= serial_in_pin ? SFB_RX_IDLE : SFB_RX_DATA;
                SFB_RX_DATA: if (rx_samp_w && rx_bit_q == nbits_w - 4'h1)
                    rx_state_q <= par_en_w ? SFB_RX_PAR : SFB_RX_STOP;
                SFB_RX_PAR: if (rx_samp_w) rx_state_q <= SFB_RX_STOP;
                SFB_RX_STOP: if (rx_samp_w) rx_state_q <= SFB_RX_IDLE;
                default: rx_state_q <= SFB_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sh_q   <= 9'h000;
            rx_bit_q  <= 4'h0;
            rx_pbit_q <= 1'b0;
        end else if (rx_state_q == SFB_RX_IDLE) begin
            rx_sh_q  <= 9'h000;
            rx_bit_q <= 4'h0;
        end else if (rx_samp_w && rx_state_q == SFB_RX_DATA) begin
            rx_sh_q[rx_bit_q] <= serial_in_pin;
            rx_bit_q <= rx_bit_q + 4'h1;
        end else if (rx_samp_w && rx_state_q == SFB_RX_PAR) begin
            rx_pbit_q <= serial_in_pin;
        end
    end

    // new frame wins over a data window read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf_q  <= 8'h00;
            rx8_q     <= 1'b0;
            rx_full_q <= 1'b0;
            perr_q    <= 1'b0;
        end else if (rx_done_w) begin
            rx_buf_q  <= rx_sh_q[7:0];
            // ninth bit shown in control B
            rx8_q     <= rx_sh_q[8];
            rx_full_q <= 1'b1;
            perr_q    <= par_en_w && (rx_par_w != rx_pbit_q);
        end else if (data_rd_w) begin
            rx_full_q <= 1'b0;
            perr_q    <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_txen_takes_pin: assert property (
        txen_q |=> tx_pin_override ##1 serial_out_pin == $past(tx_line_q))
        else $error("enabled transmitter did not take the pin");
    chk_tx_disable_wait: assert property (
        tx_active_q && (tx_state_q != SFB_TX_IDLE) |=> tx_active_q)
        else $error("transmitter released the pin mid frame");
    chk_size_nine: assert property (
        size_w == SFB_SIZE_9 |-> nbits_w == 4'h9)
        else $error("size code 111 is not nine bits");
    chk_rx_ninth_bit: assert property (
        rx_done_w |=> rx8_q == $past(rx_sh_q[8]))
        else $error("received ninth bit not presented");
    chk_tx_ninth_bit: assert property (
        tx_load_w |=> tx_sh_q[8] == $past(txbuf_q[8]))
        else $error("ninth bit not loaded for transmit");
    chk_mode_sync_clk: assert property (
        mode_w == SFB_MODE_SYNC |-> sync_clock_pin_oe)
        else $error("sync mode without driven clock");
    chk_parity_off: assert property (
        !par_en_w && tx_step_w && tx_state_q == SFB_TX_DATA
        |=> tx_state_q != SFB_TX_PAR)
        else $error("parity sent while disabled");
    chk_tx_parity_bit: assert property (
        tx_state_q == SFB_TX_DATA ##1 tx_state_q == SFB_TX_PAR
        |-> tx_line_q == $past(tx_par_w))
        else $error("wrong parity bit sent");
    chk_rx_parity_err: assert property (
        rx_done_w && par_en_w && rx_par_w != rx_pbit_q |=> perr_q)
        else $error("parity mismatch not flagged");
    chk_two_stops: assert property (
        tx_step_w && tx_state_q == SFB_TX_PAR && stop2_w
        |=> tx_stopc_q && tx_state_q == SFB_TX_STOP)
        else $error("second stop bit missing");
    chk_baud_hi_zero: assert property (
        psel && !penable && hit_bh |=> prdata[7:4] == 4'h0)
        else $error("reserved divisor bits read nonzero");
    chk_short_upper: assert property (
        rx_done_w && nbits_w == 4'h5 |=> rx_buf_q[7:5] == 3'h0)
        else $error("unused received bits not zero");

    cov_tx_frame:  cover property (tx_end_w);
    cov_rx_parity: cover property (rx_done_w && par_en_w);
    cov_sync_rx:   cover property (rx_done_w && sync_w);
    cov_nine_bit:  cover property (tx_load_w && nbits_w == 4'h9);
endmodule

// ### core/sfb_pkg.sv
// constants, types and register map of the serial frame and baud block
// Contract
// - tx enable hands output pin to transmitter
// - tx disable waits until shifter, buffer empty
// - three size bits give 5-8 or 9 bits
// - received ninth bit readable in control B
// - transmitter sends ninth-bit field as bit nine
// - mode field selects async, sync, spi; spi mode runs the same logic as sync here
// - parity field: off, reserved, even, odd
// - transmitter inserts computed parity bit per frame
// - receiver checks parity, sets parity error flag
// - stop select gives one or two stops
// - sync polarity picks transmit and sample edges
// - baud divisor is 12 bits, high nibble
// - low divisor write reloads prescaler at once
// - divisor bits 15:12 read zero, written zero
// - double speed cuts ratio 16 to 8
// - short characters: upper bits ignored, read zero
package sfb_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] SFB_OFF_STATUS = 8'h00;
    localparam logic [7:0] SFB_OFF_CTRL_B = 8'h04;
    localparam logic [7:0] SFB_OFF_FORMAT = 8'h08;
    localparam logic [7:0] SFB_OFF_BAUD_H = 8'h0C;
    localparam logic [7:0] SFB_OFF_BAUD_L = 8'h10;
    localparam logic [7:0] SFB_OFF_DATA   = 8'h14;
    // ------------------------------------------------------------
    // reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0]  SFB_FORMAT_RST = 8'h06;
    localparam logic [11:0] SFB_BAUD_RST   = 12'h000;
    localparam int SFB_ST_RXC  = 7;
    localparam int SFB_ST_TXC  = 6;
    localparam int SFB_ST_U2X  = 1;
    localparam int SFB_CB_TXEN = 3;
    localparam int SFB_CB_SZ2  = 2;
    localparam int SFB_CB_TX8  = 0;
    localparam logic [1:0] SFB_MODE_SYNC = 2'b01;
    localparam logic [1:0] SFB_MODE_SPI  = 2'b11;
    localparam logic [2:0] SFB_SIZE_9    = 3'b111;
    localparam logic [4:0] SFB_RATIO_NORM = 5'h10;
    localparam logic [4:0] SFB_RATIO_DBL  = 5'h08;
    // ------------------------------------------------------------
    // state types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SFB_TX_IDLE, SFB_TX_START, SFB_TX_DATA, SFB_TX_PAR, SFB_TX_STOP
    } sfb_tx_state_type;
    typedef enum logic [2:0] {
        SFB_RX_IDLE, SFB_RX_START, SFB_RX_DATA, SFB_RX_PAR, SFB_RX_STOP
    } sfb_rx_state_type;
endpackage

// ### core/sfb_baud_if.sv
// interface between the core and the baud generator
`timescale 1ns/1ns
interface sfb_baud_if;
    logic [11:0] divisor;
    logic        reload;
    logic        sync_mode;
    logic        double_speed;
    logic        polarity;
    logic        tick;
    logic        bit_tick;
    logic        tx_edge;
    logic        rx_edge;
    logic        xck;
    modport core (output divisor, reload, sync_mode, double_speed,
                  polarity, input tick, bit_tick, tx_edge, rx_edge, xck);
    modport gen  (input divisor, reload, sync_mode, double_speed,
                  polarity, output tick, bit_tick, tx_edge, rx_edge, xck);
endinterface

// ### core/sfb_parity.sv
// parity over the active data bits of a character
`timescale 1ns/1ns
module sfb_parity (
    input  wire logic [8:0] data,
    input  wire logic [3:0] nbits,
    input  wire logic       odd,
    output logic            par
);
    logic [8:0] mask;
    // unused upper bits never take part
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            mask[i] = (4'(i) < nbits);
        end
    end
    assign par = (^(data & mask)) ^ odd;
endmodule

// ### core/sfb_baud.sv
// baud prescaler, bit rate divider and synchronous clock
`timescale 1ns/1ns
module sfb_baud (
    input  wire logic pclk,
    input  wire logic presetn,
    sfb_baud_if.gen   bif
);
    import sfb_pkg::*;
    logic [11:0] cnt_q;
    logic [4:0]  sub_q;
    logic        xck_q;
    wire  [4:0]  ratio_w = (bif.double_speed && !bif.sync_mode) ?
                           SFB_RATIO_DBL : SFB_RATIO_NORM;
    wire         wrap_w  = (sub_q == ratio_w - 5'h01);

    assign bif.tick     = (cnt_q == 12'h000) && !bif.reload;
    assign bif.bit_tick = bif.tick && wrap_w;
    assign bif.xck      = xck_q;
    assign bif.tx_edge  = bif.tick && bif.sync_mode &&
                          (xck_q == bif.polarity);
    assign bif.rx_edge  = bif.tick && bif.sync_mode &&
                          (xck_q != bif.polarity);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= SFB_BAUD_RST;
            sub_q <= 5'h00;
            xck_q <= 1'b0;
        end else if (bif.reload) begin
            cnt_q <= bif.divisor;
            sub_q <= 5'h00;
        end else if (cnt_q == 12'h000) begin
            cnt_q <= bif.divisor;
            sub_q <= wrap_w ? 5'h00 : sub_q + 5'h01;
            xck_q <= bif.sync_mode ? ~xck_q : 1'b0;
        end else begin
            cnt_q <= cnt_q - 12'h001;
        end
    end

    chk_prescale_reload: assert property (@(posedge pclk)
        disable iff (!presetn)
        bif.tick |=> cnt_q == $past(bif.divisor))
        else $error("prescaler did not reload from divisor");
    chk_double_ratio: assert property (@(posedge pclk)
        disable iff (!presetn)
        bif.bit_tick && bif.double_speed && !bif.sync_mode
        |-> sub_q == 5'h07)
        else $error("double speed ratio is not eight");
endmodule

// ### test/sfb_line_model.sv
// remote serial party: frame receiver and frame sender on the line
`timescale 1ns/1ns
module sfb_line_model (
    input  wire logic pclk,
    input  wire logic line_in,
    output logic      line_out
);
    int bit_clks = 16;
    initial line_out = 1'b1;
    // -------------------------------------------------------------
    // receive: start edge, then n bits lsb first, sampled mid-bit
    // -------------------------------------------------------------
    task automatic recv(input int n, output logic [11:0] bits);
        bits = 12'h000;
        @(negedge line_in);
        repeat (bit_clks / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            repeat (bit_clks) @(posedge pclk);
            bits[i] = line_in;
        end
        repeat (2 * bit_clks) @(posedge pclk);
    endtask
    // -------------------------------------------------------------
    // send: start bit, n bits lsb first, then idle high
    // -------------------------------------------------------------
    task automatic send(input int n, input logic [11:0] bits);
        @(posedge pclk);
        line_out <= 1'b0;
        repeat (bit_clks) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            line_out <= bits[i];
            repeat (bit_clks) @(posedge pclk);
        end
        line_out <= 1'b1;
    endtask
endmodule

// ### test/serial_frame_baud_config_tb_top.sv
// self-checking bench of the serial frame and baud block
`timescale 1ns/1ns
module serial_frame_baud_config_tb_top;
    import sfb_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic        port_out_value, rx_line, serial_out_pin, tx_pin_override;
    logic        sync_clock_pin_o, sync_clock_pin_oe, slv;
    logic [11:0] got;
    int          fail_count = 0;
    int          compares = 0;
    sfb_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_out_value(port_out_value), .serial_in_pin(rx_line),
        .serial_out_pin(serial_out_pin), .tx_pin_override(tx_pin_override),
        .sync_clock_pin_o(sync_clock_pin_o),
        .sync_clock_pin_oe(sync_clock_pin_oe));
    sfb_line_model line_u (.pclk(pclk), .line_in(serial_out_pin),
        .line_out(rx_line));
    // -------------------------------------------------------------
    // apb master and comparison
    // -------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tx_frame(input logic [7:0] cb, fmt, d, input int n);
        wr(SFB_OFF_FORMAT, {24'h0, fmt});
        wr(SFB_OFF_CTRL_B, {24'h0, cb});
        fork
            line_u.recv(n, got);
            wr(SFB_OFF_DATA, {24'h0, d});
        join
    endtask
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_reset();
        rd(SFB_OFF_FORMAT);
        check("format reset", rdv, 32'h06);
        rd(SFB_OFF_BAUD_H);
        check("baud high reset", rdv, 32'h00);
        rd(8'h18);
        check("unmapped error", {31'h0, slv}, 32'h1);
        wr(SFB_OFF_BAUD_H, 32'h0A);
        rd(SFB_OFF_BAUD_H);
        check("baud high nibble", rdv, 32'h0A);
        wr(SFB_OFF_BAUD_H, 32'h00);
        wr(SFB_OFF_BAUD_L, 32'h00);
    endtask
    task automatic t_tx();
        tx_frame(8'h08, 8'h2E, 8'hA5, 11);
        check("override", {31'h0, tx_pin_override}, 32'h1);
        check("even 2 stop", {20'h0, got}, 32'h6A5);
        tx_frame(8'h0D, 8'h36, 8'h3C, 11);
        check("odd ninth", {20'h0, got}, 32'h53C);
    endtask
    task automatic t_rx();
        rdv = 32'h0;
        wr(SFB_OFF_FORMAT, 32'h26);
        wr(SFB_OFF_CTRL_B, 32'h0C);
        line_u.send(11, 12'h5F5);
        for (int i = 0; i < 50 && rdv[7] !== 1'b1; i++) rd(SFB_OFF_STATUS);
        check("parity error", rdv & 32'h84, 32'h84);
        rd(SFB_OFF_CTRL_B);
        check("rx ninth", rdv & 32'h02, 32'h02);
        rd(SFB_OFF_DATA);
        check("rx data", rdv, 32'hF5);
    endtask
    task automatic t_rate_stop();
        line_u.bit_clks = 24;
        wr(SFB_OFF_BAUD_H, 32'h00);
        wr(SFB_OFF_BAUD_L, 32'h02);
        wr(SFB_OFF_STATUS, 32'h02);
        wr(SFB_OFF_FORMAT, 32'h00);
        fork
            line_u.recv(6, got);
            begin
                wr(SFB_OFF_DATA, 32'h1A);
                wr(SFB_OFF_CTRL_B, 32'h00);
                check("held", {31'h0, tx_pin_override}, 32'h1);
            end
        join
        check("5 bit rate", {20'h0, got}, 32'h3A);
        check("released", {31'h0, tx_pin_override}, 32'h0);
        port_out_value <= 1'b0;
        repeat (3) @(posedge pclk);
        check("port level", {31'h0, serial_out_pin}, 32'h0);
        line_u.send(6, 12'h035);
        rd(SFB_OFF_DATA);
        check("rx short", rdv, 32'h15);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(SFB_OFF_FORMAT, m << 6);
            repeat (3) @(posedge pclk);
            check("clock oe", {31'h0, sync_clock_pin_oe},
                  {31'h0, m[0]});
        end
        line_u.bit_clks = 6;
        port_out_value <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            tx_frame(8'h08, 8'h46 | p[7:0], 8'h96, 9);
            check("sync frame", {20'h0, got}, 32'h196);
        end
    endtask
    // -------------------------------------------------------------
    // clock, reset, sequence, watchdog
    // -------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        complete_run();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        port_out_value = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_rate_stop();
        t_modes();
        complete_run();
    end
endmodule
